// ===== shared/port_pad_pkg.sv
// Constants and types shared by the port S pad and routing block.
// Assumes a 32-bit classic Wishbone bus with 12-bit byte addresses.
package port_pad_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int PIN_COUNT = 6;
  localparam int TIMER_PINS = 4;
  localparam int REG_WIDTH = 8;
  localparam int ADDR_WIDTH = 12;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [11:0] ROUTING_INDEX = 12'h24F;
  localparam logic [11:0] ADDR_ROUTING = {ROUTING_INDEX[9:0], 2'b00};
  localparam logic [11:0] ADDR_DIRECTION = 12'h900;
  localparam logic [11:0] ADDR_PULL_ENABLE = 12'h904;
  localparam logic [11:0] ADDR_PULL_POLARITY = 12'h908;
  localparam logic [11:0] ADDR_OPEN_DRAIN = 12'h90C;
  localparam logic [11:0] ADDR_PORT_DATA = 12'h910;
  localparam logic [11:0] ADDR_LIN_DRIVE = 12'h914;
  localparam logic [11:0] ADDR_PIN_INPUT = 12'h918;
  localparam logic [11:0] ADDR_ROUTE_STATUS = 12'h91C;

  // ****************************************
  // Field positions and codes
  // ****************************************
  localparam int ROUTE_TIMER_BIT = 7;
  localparam int ROUTE_SPI_BIT = 5;
  localparam int ROUTE_SERIAL_ONE_BIT = 4;
  localparam int LIN_DIRECT_DRIVE_BIT = 1;
  localparam logic [3:0] LIN_DEFAULT = 4'h0;
  localparam logic [3:0] LIN_DIRECT = 4'h1;
  localparam logic [3:0] LIN_PROBE = 4'hC;
  localparam logic [3:0] LIN_CONFORM = 4'hE;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] ROUTING_RESET = 8'h00;
  localparam logic [5:0] PAD_RESET = 6'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // Bus answer phase
  typedef enum logic {BUS_IDLE, BUS_ACK} bus_phase_e;

endpackage

// ===== src/pad_cell_config.sv
// One port pin pad: output driver and pull device control.
// Assumes direction and value are already resolved by the routing logic.
`timescale 1ns/1ps
module pad_cell_config
  import port_pad_pkg::*;
(
  // Resolved pin function
  input wire logic dir_out_i,
  input wire logic value_i,
  // Pad settings
  input wire logic open_drain_i,
  input wire logic pull_enable_i,
  input wire logic pull_polarity_i,
  // Pad controls
  output logic pad_out_o,
  output logic pad_oe_n_o,
  output logic pull_on_o,
  output logic pull_down_o
);

  // Open drain drives only zeros; input pins ignore the open-drain bit
  assign pad_out_o = open_drain_i ? 1'b0 : value_i;
  assign pad_oe_n_o = ~(dir_out_i & (~open_drain_i | ~value_i));

  // Pull acts on inputs, and on outputs only in open-drain mode
  assign pull_on_o = pull_enable_i & (~dir_out_i | open_drain_i);
  assign pull_down_o = pull_on_o & pull_polarity_i;

endmodule

// ===== src/write_once_reg.sv
// Register that takes one write in normal mode and any write in special mode.
// Assumes write_i is a one-cycle strobe from the bus slave.
`timescale 1ns/1ps
module write_once_reg
  import port_pad_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Write side
  input wire logic write_i,
  input wire logic special_mode_i,
  input wire logic [WIDTH-1:0] data_i,
  // State
  output logic [WIDTH-1:0] value_o,
  output logic locked_o
);

  typedef struct packed {
    logic [WIDTH-1:0] value;
    logic locked;
  } state_s;

  state_s r;
  state_s next_r;

  // Accept first normal write, all special-mode writes
  always_comb
  begin
    next_r = r;
    if (write_i && (special_mode_i || !r.locked))
    begin
      next_r.value = data_i;
      next_r.locked = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r <= '{value: RESET_VALUE, locked: 1'b0};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign value_o = r.value;
  assign locked_o = r.locked;

endmodule

// ===== src/port_pad_config_routing.sv
// Port S pad configuration and peripheral routing with a Wishbone slave.
// Assumes peripherals sit on the same clock and pins are synchronous.
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
module port_pad_config_routing
  import port_pad_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_WIDTH-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Operating mode
  input wire logic special_mode_i,
  // Serial port zero
  input wire logic serial_zero_enable_i,
  input wire logic serial_zero_transmit_i,
  output logic serial_zero_receive_o,
  // Serial port one
  input wire logic serial_one_enable_i,
  input wire logic serial_one_transmit_i,
  output logic serial_one_receive_o,
  // SPI select and clock
  input wire logic spi_enable_i,
  input wire logic spi_ss_out_i,
  input wire logic spi_ss_drive_i,
  input wire logic spi_sck_out_i,
  input wire logic spi_sck_drive_i,
  output logic spi_ss_in_o,
  output logic spi_sck_in_o,
  // Transceiver and timer
  input wire logic lin_transceiver_enable_i,
  input wire logic lin_phy_receive_out_i,
  output logic lin_phy_transmit_in_o,
  output logic timer_capture_three_o,
  // Port S pads
  input wire logic [PIN_COUNT-1:0] port_s_in_i,
  output logic [PIN_COUNT-1:0] port_s_out_o,
  output logic [PIN_COUNT-1:0] port_s_oe_n_o,
  output logic [PIN_COUNT-1:0] pull_on_o,
  output logic [PIN_COUNT-1:0] pull_down_o,
  // Timer pins claimed by routing
  input wire logic [TIMER_PINS-1:0] timer_pin_in_i,
  output logic [TIMER_PINS-1:0] timer_pin_out_o,
  output logic [TIMER_PINS-1:0] timer_pin_oe_n_o,
  output logic [TIMER_PINS-1:0] timer_pin_claim_o
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    bus_phase_e phase;
    logic [REG_WIDTH-1:0] rdata;
    logic [PIN_COUNT-1:0] direction;
    logic [PIN_COUNT-1:0] pull_enable;
    logic [PIN_COUNT-1:0] pull_polarity;
    logic [PIN_COUNT-1:0] open_drain;
    logic [PIN_COUNT-1:0] port_data;
    logic lin_drive;
  } regs_s;

  regs_s r;
  regs_s next_r;

  logic [REG_WIDTH-1:0] routing;
  logic routing_locked;
  logic routing_write;
  logic [3:0] lin_mode;
  logic [PIN_COUNT-1:0] fn_active;
  logic [PIN_COUNT-1:0] fn_value;
  logic [PIN_COUNT-1:0] fn_dir;
  logic [PIN_COUNT-1:0] pin_dir;
  logic [PIN_COUNT-1:0] pin_value;
  logic lin_owns_pt3;
  logic lin_owns_pt2;

  // Widen a pin field into a register byte
  function automatic logic [REG_WIDTH-1:0] widen(input logic [PIN_COUNT-1:0] v);
    widen = {{(REG_WIDTH - PIN_COUNT){1'b0}}, v};
  endfunction

  // Register read decode
  function automatic logic [REG_WIDTH-1:0] read_reg(
    input logic [ADDR_WIDTH-1:0] a,
    input regs_s s,
    input logic [REG_WIDTH-1:0] route,
    input logic locked,
    input logic [PIN_COUNT-1:0] pins
  );
    case (a)
      ADDR_ROUTING: read_reg = route;
      ADDR_DIRECTION: read_reg = widen(s.direction);
      ADDR_PULL_ENABLE: read_reg = widen(s.pull_enable);
      ADDR_PULL_POLARITY: read_reg = widen(s.pull_polarity);
      ADDR_OPEN_DRAIN: read_reg = widen(s.open_drain);
      ADDR_PORT_DATA: read_reg = widen(s.port_data);
      ADDR_LIN_DRIVE: read_reg = {6'h00, s.lin_drive, 1'b0};
      ADDR_PIN_INPUT: read_reg = widen(pins);
      ADDR_ROUTE_STATUS: read_reg = {7'h00, locked};
      default: read_reg = READ_IDLE;
    endcase
  endfunction

  // ****************************************
  // Bus slave and registers
  // ****************************************

  // Answer one cycle after request; write lands at the acknowledged edge
  always_comb
  begin
    next_r = r;
    routing_write = 1'b0;
    case (r.phase)
      BUS_IDLE:
      begin
        if (cyc_i && stb_i)
        begin
          next_r.phase = BUS_ACK;
          next_r.rdata = read_reg(adr_i, r, routing, routing_locked, port_s_in_i);
        end
      end
      BUS_ACK:
      begin
        next_r.phase = BUS_IDLE;
        if (cyc_i && stb_i && we_i && sel_i[0])
        begin
          case (adr_i)
            ADDR_ROUTING: routing_write = 1'b1;
            ADDR_DIRECTION: next_r.direction = dat_i[PIN_COUNT-1:0];
            ADDR_PULL_ENABLE: next_r.pull_enable = dat_i[PIN_COUNT-1:0];
            ADDR_PULL_POLARITY: next_r.pull_polarity = dat_i[PIN_COUNT-1:0];
            ADDR_OPEN_DRAIN: next_r.open_drain = dat_i[PIN_COUNT-1:0];
            ADDR_PORT_DATA: next_r.port_data = dat_i[PIN_COUNT-1:0];
            ADDR_LIN_DRIVE: next_r.lin_drive = dat_i[LIN_DIRECT_DRIVE_BIT];
            default: next_r.phase = BUS_IDLE;
          endcase
        end
      end
      default: next_r.phase = BUS_IDLE;
    endcase
  end

  // Register bank
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r.phase <= BUS_IDLE;
      r.rdata <= READ_IDLE;
      r.direction <= PAD_RESET;
      r.pull_enable <= PAD_RESET;
      r.pull_polarity <= PAD_RESET;
      r.open_drain <= PAD_RESET;
      r.port_data <= PAD_RESET;
      r.lin_drive <= 1'b0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign ack_o = (r.phase == BUS_ACK);
  assign dat_o = {24'h000000, r.rdata};

  // Write-once routing register
  write_once_reg #(
    .WIDTH(REG_WIDTH),
    .RESET_VALUE(ROUTING_RESET)
  ) u_routing (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .write_i(routing_write),
    .special_mode_i(special_mode_i),
    .data_i(dat_i[REG_WIDTH-1:0]),
    .value_o(routing),
    .locked_o(routing_locked)
  );

  // ****************************************
  // Transceiver link routing
  // ****************************************
  assign lin_mode = routing[3:0];

  // Link mux; unlisted codes behave as the default setting
  always_comb
  begin
    lin_phy_transmit_in_o = serial_zero_transmit_i;
    serial_zero_receive_o = lin_phy_receive_out_i;
    timer_pin_out_o = 4'h0;
    timer_pin_oe_n_o = 4'hF;
    timer_pin_claim_o = 4'h0;
    lin_owns_pt3 = 1'b0;
    lin_owns_pt2 = 1'b0;
    case (lin_mode)
      LIN_DIRECT:
      begin
        // Direct bit only drives while the transceiver is on
        lin_phy_transmit_in_o = lin_transceiver_enable_i ? r.lin_drive : 1'b1;
      end
      LIN_PROBE:
      begin
        // Link stays joined; transmit on timer pin 3, receive on timer pin 2
        lin_owns_pt3 = 1'b1;
        lin_owns_pt2 = 1'b1;
        timer_pin_claim_o[3] = 1'b1;
        timer_pin_claim_o[2] = 1'b1;
        timer_pin_out_o[3] = serial_zero_transmit_i;
        timer_pin_oe_n_o[3] = ~serial_zero_enable_i;
        timer_pin_out_o[2] = lin_phy_receive_out_i;
        timer_pin_oe_n_o[2] = ~lin_transceiver_enable_i;
      end
      LIN_CONFORM:
      begin
        // Link opened: four signals on four timer pins, pins 3 and 2 only while the transceiver is on
        serial_zero_receive_o = timer_pin_in_i[0];
        timer_pin_claim_o[1:0] = 2'b11;
        timer_pin_out_o[1] = serial_zero_transmit_i;
        timer_pin_oe_n_o[1] = ~serial_zero_enable_i;
        lin_phy_transmit_in_o = lin_transceiver_enable_i ? timer_pin_in_i[3] : 1'b1;
        lin_owns_pt3 = lin_transceiver_enable_i;
        lin_owns_pt2 = lin_transceiver_enable_i;
        timer_pin_claim_o[3] = lin_transceiver_enable_i;
        timer_pin_claim_o[2] = lin_transceiver_enable_i;
        timer_pin_out_o[2] = lin_phy_receive_out_i;
        timer_pin_oe_n_o[2] = ~lin_transceiver_enable_i;
      end
      default: lin_phy_transmit_in_o = serial_zero_transmit_i;
    endcase
    // SPI on timer pins when they are not held by the link
    if (routing[ROUTE_SPI_BIT] && spi_enable_i)
    begin
      if (!lin_owns_pt3)
      begin
        timer_pin_claim_o[3] = 1'b1;
        timer_pin_out_o[3] = spi_ss_out_i;
        timer_pin_oe_n_o[3] = ~spi_ss_drive_i;
      end
      if (!lin_owns_pt2)
      begin
        timer_pin_claim_o[2] = 1'b1;
        timer_pin_out_o[2] = spi_sck_out_i;
        timer_pin_oe_n_o[2] = ~spi_sck_drive_i;
      end
    end
  end

  // Capture three source
  assign timer_capture_three_o = routing[ROUTE_TIMER_BIT] ?
    lin_phy_receive_out_i : timer_pin_in_i[3];

  // SPI and serial one input selection
  assign spi_ss_in_o = routing[ROUTE_SPI_BIT] ? timer_pin_in_i[3] : port_s_in_i[5];
  assign spi_sck_in_o = routing[ROUTE_SPI_BIT] ? timer_pin_in_i[2] : port_s_in_i[4];
  assign serial_one_receive_o = routing[ROUTE_SERIAL_ONE_BIT] ?
    port_s_in_i[2] : port_s_in_i[0];

  // ****************************************
  // Port S pin functions
  // ****************************************

  // Peripheral claims on port S pins
  always_comb
  begin
    fn_active = 6'h00;
    fn_value = 6'h00;
    fn_dir = 6'h00;
    if (serial_one_enable_i)
    begin
      if (routing[ROUTE_SERIAL_ONE_BIT])
      begin
        fn_active[3:2] = 2'b11;
        fn_value[3] = serial_one_transmit_i;
        fn_dir[3] = 1'b1;
      end
      else
      begin
        fn_active[1:0] = 2'b11;
        fn_value[1] = serial_one_transmit_i;
        fn_dir[1] = 1'b1;
      end
    end
    if (spi_enable_i && !routing[ROUTE_SPI_BIT])
    begin
      fn_active[5:4] = 2'b11;
      fn_value[5] = spi_ss_out_i;
      fn_value[4] = spi_sck_out_i;
      fn_dir[5] = spi_ss_drive_i;
      fn_dir[4] = spi_sck_drive_i;
    end
  end

  // Direction bit unless a peripheral forces it
  assign pin_dir = (fn_active & fn_dir) | (~fn_active & r.direction);
  assign pin_value = (fn_active & fn_value) | (~fn_active & r.port_data);

  // Pad cells
  for (genvar i = 0; i < PIN_COUNT; i++)
  begin : g_pad
    pad_cell_config u_pad (
      .dir_out_i(pin_dir[i]),
      .value_i(pin_value[i]),
      .open_drain_i(r.open_drain[i]),
      .pull_enable_i(r.pull_enable[i]),
      .pull_polarity_i(r.pull_polarity[i]),
      .pad_out_o(port_s_out_o[i]),
      .pad_oe_n_o(port_s_oe_n_o[i]),
      .pull_on_o(pull_on_o[i]),
      .pull_down_o(pull_down_o[i])
    );
  end

endmodule

// ===== verification/periph_model.sv
// Peripheral and pin level source for the port S routing bench.
// Assumes one clock; every level can change from cycle to cycle.
`timescale 1ns/1ps
module periph_model (
  // Clock
  input wire logic clk_i,
  // Peripheral and pin levels
  output logic serial_zero_transmit_o,
  output logic serial_one_transmit_o,
  output logic lin_phy_receive_out_o,
  output logic spi_ss_out_o,
  output logic spi_sck_out_o,
  output logic [3:0] timer_pin_o,
  output logic [5:0] port_s_pin_o
);
  logic [15:0] lfsr = 16'hACE1;
  // Shift each cycle so a stale or swapped line shows up
  always @(posedge clk_i)
  begin
    lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
  end
  // Spread the pattern over the lines
  assign serial_zero_transmit_o = lfsr[0];
  assign serial_one_transmit_o = lfsr[1];
  assign lin_phy_receive_out_o = lfsr[2];
  assign spi_ss_out_o = lfsr[3];
  assign spi_sck_out_o = lfsr[4];
  assign timer_pin_o = lfsr[8:5];
  assign port_s_pin_o = lfsr[14:9];
endmodule

// ===== verification/port_pad_assertions.sv
// Checker for the port S pad and routing block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module port_pad_assertions
  import port_pad_pkg::*;
(
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_WIDTH-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Mode, link and pads
  input wire logic special_mode_i,
  input wire logic serial_zero_transmit_i,
  input wire logic serial_zero_receive_o,
  input wire logic lin_transceiver_enable_i,
  input wire logic lin_phy_receive_out_i,
  input wire logic lin_phy_transmit_in_o,
  input wire logic timer_capture_three_o,
  input wire logic [TIMER_PINS-1:0] timer_pin_in_i,
  input wire logic [PIN_COUNT-1:0] port_s_out_o,
  input wire logic [PIN_COUNT-1:0] port_s_oe_n_o,
  input wire logic [PIN_COUNT-1:0] pull_on_o,
  input wire logic [PIN_COUNT-1:0] pull_down_o
);
  // ****
  // Shadow registers
  // ****
  logic [7:0] pe, pp, od, route, drv;
  logic locked;
  logic wr;
  assign wr = ack_o && cyc_i && stb_i && we_i && sel_i[0];
  // Follow accepted pull, open-drain, drive and routing writes at their ack edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      {pe, pp, od, route, drv} <= 40'h0;
      locked <= 1'b0;
    end
    else if (wr)
    begin
      if (adr_i == ADDR_PULL_ENABLE) pe <= dat_i[7:0];
      if (adr_i == ADDR_PULL_POLARITY) pp <= dat_i[7:0];
      if (adr_i == ADDR_OPEN_DRAIN) od <= dat_i[7:0];
      if (adr_i == ADDR_LIN_DRIVE) drv <= dat_i[7:0];
      if (adr_i == ADDR_ROUTING && (!locked || special_mode_i))
      begin
        route <= dat_i[7:0];
        locked <= 1'b1;
      end
    end
  end
  // ****
  // Properties
  // ****
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_answer;
    ack_o ##1 !ack_o;
  endsequence
  a_ack_latency: assert property (s_req |=> s_answer) else $error("ack timing wrong");
  a_ack_idle: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("stray ack");
  a_read_upper: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h0)
    else $error("read upper bits set");
  a_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && pull_on_o == 6'h00
    && port_s_oe_n_o == 6'h3F) else $error("pads not idle after reset");
  a_pull_enable: assert property (pull_on_o == (pe[5:0] & (port_s_oe_n_o | od[5:0])))
    else $error("pull enable wrong");
  a_pull_polarity: assert property ((pull_on_o & (pull_down_o ^ pp[5:0])) == 6'h00)
    else $error("pull polarity wrong");
  a_open_drain: assert property ((od[5:0] & ~port_s_oe_n_o & port_s_out_o) == 6'h00)
    else $error("open drain drives high");
  a_capture_src: assert property (timer_capture_three_o ==
    (route[7] ? lin_phy_receive_out_i : timer_pin_in_i[3])) else $error("capture source wrong");
  a_default_link: assert property (route[3:0] == LIN_DEFAULT |->
    lin_phy_transmit_in_o == serial_zero_transmit_i
    && serial_zero_receive_o == lin_phy_receive_out_i) else $error("default link wrong");
  a_direct_drive: assert property (route[3:0] == LIN_DIRECT |-> lin_phy_transmit_in_o ==
    (lin_transceiver_enable_i ? drv[LIN_DIRECT_DRIVE_BIT] : 1'b1)) else $error("direct drive wrong");
endmodule
bind port_pad_config_routing port_pad_assertions i_port_pad_assertions (
  .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
  .special_mode_i, .serial_zero_transmit_i, .serial_zero_receive_o, .lin_transceiver_enable_i,
  .lin_phy_receive_out_i, .lin_phy_transmit_in_o, .timer_capture_three_o, .timer_pin_in_i,
  .port_s_out_o, .port_s_oe_n_o, .pull_on_o, .pull_down_o
);

// ===== verification/port_pad_config_routing_tb.sv
// Self-checking bench for the port S pad and routing block.
// Assumes the peripheral model drives all peripheral and pin levels.
`timescale 1ns/1ps
module port_pad_config_routing_tb import port_pad_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, special_mode_i = 1'b0;
  logic serial_zero_enable_i = 1'b0, serial_one_enable_i = 1'b0, spi_enable_i = 1'b0;
  logic lin_transceiver_enable_i = 1'b0, spi_ss_drive_i = 1'b1, spi_sck_drive_i = 1'b0;
  logic [11:0] adr_i = 12'h000;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, v;
  logic ack_o, serial_zero_transmit_i, serial_zero_receive_o, serial_one_transmit_i;
  logic serial_one_receive_o, spi_ss_out_i, spi_sck_out_i, spi_ss_in_o, spi_sck_in_o;
  logic lin_phy_receive_out_i, lin_phy_transmit_in_o, timer_capture_three_o, drv;
  logic [5:0] port_s_in_i, port_s_out_o, port_s_oe_n_o, pull_on_o, pull_down_o, oe, pl;
  logic [3:0] timer_pin_in_i, timer_pin_out_o, timer_pin_oe_n_o, timer_pin_claim_o;
  logic [31:0] rdq[$];
  logic [11:0] regs [9] = '{ADDR_ROUTING, ADDR_DIRECTION, ADDR_PULL_ENABLE, ADDR_PULL_POLARITY,
    ADDR_OPEN_DRAIN, ADDR_PORT_DATA, ADDR_LIN_DRIVE, ADDR_ROUTE_STATUS, 12'h0F0};
  logic [11:0] tbl [8] = '{12'h303, 12'h00F, 12'h8CC, 12'h0C0, 12'h0EC, 12'h0E8, 12'h018, 12'h01D};
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;
  // ****
  // Design and peripheral model
  // ****
  port_pad_config_routing i_port_pad_config_routing (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .special_mode_i, .serial_zero_enable_i, .serial_zero_transmit_i, .serial_zero_receive_o,
    .serial_one_enable_i, .serial_one_transmit_i, .serial_one_receive_o, .spi_enable_i,
    .spi_ss_out_i, .spi_ss_drive_i, .spi_sck_out_i, .spi_sck_drive_i, .spi_ss_in_o,
    .spi_sck_in_o, .lin_transceiver_enable_i, .lin_phy_receive_out_i, .lin_phy_transmit_in_o,
    .timer_capture_three_o, .port_s_in_i, .port_s_out_o, .port_s_oe_n_o, .pull_on_o,
    .pull_down_o, .timer_pin_in_i, .timer_pin_out_o, .timer_pin_oe_n_o, .timer_pin_claim_o
  );
  periph_model i_periph_model (
    .clk_i(clk_i),
    .serial_zero_transmit_o(serial_zero_transmit_i),
    .serial_one_transmit_o(serial_one_transmit_i),
    .lin_phy_receive_out_o(lin_phy_receive_out_i),
    .spi_ss_out_o(spi_ss_out_i),
    .spi_sck_out_o(spi_sck_out_i),
    .timer_pin_o(timer_pin_in_i),
    .port_s_pin_o(port_s_in_i)
  );
  // ****
  // Tasks
  // ****
  task automatic close_out;
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check_rd(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_io(input logic [5:0] got, input logic [5:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h000000, d};
    do
    begin
      @(posedge clk_i);
    end
    while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    rdq.push_back({24'h000000, e});
    wb(1'b0, a, 8'h00);
  endtask
  task automatic chk_route(input logic [7:0] r);
    repeat (4)
    begin
      @(negedge clk_i);
      check_io(timer_capture_three_o, r[7] ? lin_phy_receive_out_i : timer_pin_in_i[3]);
      if (r[3:0] != LIN_CONFORM)
        check_io(serial_zero_receive_o, lin_phy_receive_out_i);
      if (r[3:0] == LIN_DEFAULT || r[3:0] == LIN_PROBE)
        check_io(lin_phy_transmit_in_o, serial_zero_transmit_i);
      if (r[3:0] == LIN_DIRECT)
        check_io(lin_phy_transmit_in_o, lin_transceiver_enable_i ? drv : 1'b1);
      if (r[3:0] == LIN_PROBE)
        check_io({timer_pin_oe_n_o[3:2], 4'h0},
          {~serial_zero_enable_i, ~lin_transceiver_enable_i, 4'h0});
      if (r[3:0] == LIN_PROBE && serial_zero_enable_i)
        check_io(timer_pin_out_o[3], serial_zero_transmit_i);
      if (r[3:0] == LIN_PROBE && lin_transceiver_enable_i)
        check_io(timer_pin_out_o[2], lin_phy_receive_out_i);
      if (r[3:0] == LIN_CONFORM)
      begin
        check_io(serial_zero_receive_o, timer_pin_in_i[0]);
        check_io(timer_pin_out_o[1], serial_zero_transmit_i);
        check_io(timer_pin_claim_o[3:2], {2{lin_transceiver_enable_i}});
      end
      if (r[3:0] == LIN_CONFORM && lin_transceiver_enable_i)
        check_io(lin_phy_transmit_in_o, timer_pin_in_i[3]);
      if (spi_enable_i)
      begin
        check_io(spi_sck_in_o, r[5] ? timer_pin_in_i[2] : port_s_in_i[4]);
        check_io(spi_ss_in_o, r[5] ? timer_pin_in_i[3] : port_s_in_i[5]);
        check_io(r[5] ? timer_pin_out_o[3] : port_s_out_o[5], spi_ss_out_i);
      end
      if (serial_one_enable_i)
      begin
        check_io(serial_one_receive_o, port_s_in_i[r[4] ? 2 : 0]);
        check_io(port_s_out_o[r[4] ? 3 : 1], serial_one_transmit_i);
      end
    end
    @(posedge clk_i);
  endtask
  // ****
  // Processes
  // ****
  // Clock at 20 MHz
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end
  // Compare each read answer with the oldest note
  always @(posedge clk_i)
  begin
    if (ack_o === 1'b1 && we_i === 1'b0 && rdq.size() > 0)
      check_rd(dat_o, rdq.pop_front());
  end
  // Cut a hang short
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles > 4000)
    begin
      err_count++;
      close_out();
    end
  end
  // Main sequence
  initial
  begin
    v = $urandom(97301);
    drv = 1'b0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (regs[k]) rd(regs[k], 8'h00);
    wb(1'b1, 12'h0F0, 8'hFF);
    rd(12'h0F0, 8'h00);
    // A write without byte lane 0 must leave the register alone
    sel_i <= 4'hE;
    wb(1'b1, ADDR_PULL_ENABLE, 8'h3F);
    sel_i <= 4'hF;
    rd(ADDR_PULL_ENABLE, 8'h00);
    @(negedge clk_i);
    check_io(pull_on_o, 6'h00);
    check_io(port_s_oe_n_o, 6'h3F);
    @(posedge clk_i);
    // Random pad settings
    repeat (8)
    begin
      v = $urandom;
      wb(1'b1, ADDR_DIRECTION, {2'b00, v[5:0]});
      wb(1'b1, ADDR_PORT_DATA, {2'b00, v[11:6]});
      wb(1'b1, ADDR_OPEN_DRAIN, {2'b00, v[17:12]});
      wb(1'b1, ADDR_PULL_ENABLE, {2'b00, v[23:18]});
      wb(1'b1, ADDR_PULL_POLARITY, {2'b00, v[29:24]});
      rd(ADDR_PULL_ENABLE, {2'b00, v[23:18]});
      rd(ADDR_PULL_POLARITY, {2'b00, v[29:24]});
      @(negedge clk_i);
      oe = ~(v[5:0] & ~(v[17:12] & v[11:6]));
      pl = v[23:18] & (~v[5:0] | v[17:12]);
      check_io(port_s_oe_n_o, oe);
      check_io(port_s_out_o & ~oe, v[11:6] & ~v[17:12] & ~oe);
      check_io(pull_on_o, pl);
      check_io(pull_down_o & pl, v[29:24] & pl);
      @(posedge clk_i);
    end
    // Routing in normal mode locks after one write
    serial_zero_enable_i <= 1'b1;
    lin_transceiver_enable_i <= 1'b1;
    wb(1'b1, ADDR_OPEN_DRAIN, 8'h00);
    wb(1'b1, ADDR_LIN_DRIVE, 8'h02);
    drv = 1'b1;
    wb(1'b1, ADDR_ROUTING, 8'h81);
    chk_route(8'h81);
    wb(1'b1, ADDR_LIN_DRIVE, 8'h00);
    drv = 1'b0;
    wb(1'b1, ADDR_ROUTING, 8'h00);
    rd(ADDR_ROUTING, 8'h81);
    rd(ADDR_ROUTE_STATUS, 8'h01);
    chk_route(8'h81);
    // Special mode walks every link code; one entry frees the timer pins
    special_mode_i <= 1'b1;
    foreach (tbl[k])
    begin
      {serial_zero_enable_i, lin_transceiver_enable_i, spi_enable_i,
        serial_one_enable_i} <= tbl[k][3:0];
      wb(1'b1, ADDR_ROUTING, tbl[k][11:4]);
      rd(ADDR_ROUTING, tbl[k][11:4]);
      chk_route(tbl[k][11:4]);
    end
    close_out();
  end
endmodule
